// >>> ldp_defs.svh
// Constants for the log and diagnostic page handler
`ifndef LDP_DEFS_SVH
`define LDP_DEFS_SVH
`define LDP_SUPP_DIAG_CODE 8'h00
`define LDP_HDR_LEN 16'h0004
`define LDP_PCB_DU 7
`define LDP_PCB_DS 6
`define LDP_PCB_TSD 5
`define LDP_PCB_ETC 4
`define LDP_PCB_TMC_HI 3
`define LDP_PCB_TMC_LO 2
`define LDP_PCB_LP 0
`define LDP_PAGE_CODE_MASK 8'h3f
`define LDP_TMC_EVERY 2'h0
`define LDP_TMC_EQUAL 2'h1
`define LDP_TMC_NEQUAL 2'h2
`define LDP_TMC_GREATER 2'h3
`define LDP_SK_ILLEGAL_REQUEST 4'h5
`define LDP_SK_UNIT_ATTENTION 4'h6
`define LDP_ASC_INVALID_PARAM_LIST 8'h26
`define LDP_ASC_THRESHOLD_MET 8'h5d
`define LDP_ASCII_LO 8'h20
`define LDP_ASCII_HI 8'h7e
`define LDP_SAVE_PERIOD 32'd4096
`endif

// >>> ldp_pkg.sv
// Types for the log and diagnostic page handler
package ldp_pkg;
	typedef struct packed {
		logic valid;
		logic [3:0] senseKey;
		logic [7:0] addSense;
	} ldp_status_type;
	typedef struct packed {
		logic updateInhibit;
		logic saveInhibit;
		logic implicitSaveInhibit;
		logic compareEnable;
		logic [1:0] thresholdMatchCriterion;
		logic stringParameterFlag;
	} ldp_ctrl_type;
	typedef enum logic [1:0] {
		LDP_CMD_SEND_DIAG,
		LDP_CMD_LOG_SELECT,
		LDP_CMD_LOG_SENSE
	} ldp_cmd_type;
endpackage

// >>> ldp_counter.sv
// One cumulative log counter with threshold compare
`timescale 1ns/1ps
`include "ldp_defs.svh"
module ldp_counter #(
	parameter int WIDTH = 16
) (
	input wire logic clock, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic countEvent, // Counted event
	input wire logic freeze, // Page-wide stop
	input wire logic loadEn, // Select writes value
	input wire logic [WIDTH-1:0] loadValue, // Value written
	input wire logic [WIDTH-1:0] threshold, // Threshold copy
	input wire logic compareEnable, // Compare enable
	input wire logic [1:0] criterion, // Match criterion
	output logic [WIDTH-1:0] value, // Cumulative value
	output logic atMax, // Counter saturated
	output logic thresholdHit // Comparison true pulse
);
	logic [WIDTH-1:0] valueReg, valueNext;
	logic duReg, duNext;
	logic hitReg, hitNext;
	logic match;
	logic bump;

	always_comb begin
		bump = countEvent && !duReg && !freeze && !(&valueReg); // [RL10] [RL18]
		valueNext = valueReg;
		duNext = duReg;
		if (loadEn) begin
			valueNext = loadValue; // [RL10]
			duNext = 1'b0;
		end else if (bump) begin
			valueNext = valueReg + {{(WIDTH-1){1'b0}}, 1'b1};
			if (&(valueReg + {{(WIDTH-1){1'b0}}, 1'b1}))
				duNext = 1'b1; // [RL18]
		end
		unique case (criterion) // [RL15]
			`LDP_TMC_EVERY: match = 1'b1;
			`LDP_TMC_EQUAL: match = valueNext == threshold;
			`LDP_TMC_NEQUAL: match = valueNext != threshold;
			`LDP_TMC_GREATER: match = valueNext > threshold;
		endcase
		hitNext = compareEnable && (loadEn || bump) && match; // [RL14] [RL16]
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			valueReg <= '0;
			duReg <= 1'b0;
			hitReg <= 1'b0;
		end else begin
			valueReg <= valueNext;
			duReg <= duNext;
			hitReg <= hitNext;
		end
	end

	assign value = valueReg;
	assign atMax = duReg;
	assign thresholdHit = hitReg;

	AST_NO_WRAP: assert property (@(posedge clock) disable iff (!rst_n)
		(&valueReg) && !loadEn |=> (&valueReg)) else $error("Counter wrapped"); // [RL18]
	AST_NO_CMP: assert property (@(posedge clock) disable iff (!rst_n)
		!compareEnable |=> !thresholdHit) else $error("Compare while disabled"); // [RL14]
endmodule

// >>> ldp_page_handler.sv
// Log and diagnostic page parser and responder
// Function
// [RL1] Supported-diagnostics page code 00h is implemented.
// [RL2] Nonzero length on supported-diagnostics send ends with illegal request.
// [RL3] Header-only send arms the supported list for the next receive.
// [RL4] Returned list holds all codes ascending, first 00h.
// [RL5] Header: code, reserved, big-endian list length, list from byte 4.
// [RL6] Select accepts zero or more pages; sense returns exactly one page.
// [RL7] Log page header: six-bit code, reserved byte, big-endian length.
// [RL8] Page length cutting a parameter short ends with illegal request.
// [RL9] Parameter header: code, control byte, value length, then value.
// [RL10] Update-inhibit clear counts events; set changes only on select.
// [RL11] Update-inhibit bits received in select are ignored.
// [RL12] Save-inhibit clear saves on save-parameters request.
// [RL13] Implicit-save-inhibit clear saves periodically by own method.
// [RL14] Compare-enable set compares on every cumulative change.
// [RL15] Criterion: every update, equal, not equal, greater.
// [RL16] Criterion meaningful only with compare enabled.
// [RL17] True comparison raises unit attention, threshold condition met.
// [RL18] Data counter saturates at maximum and sets update-inhibit.
// [RL19] String parameter has no compare fields, ASCII 20h to 7Eh; value bytes are not checked against that range.
// [RL20] Parse steps parameter by parameter until page length consumed.
`timescale 1ns/1ps
`include "ldp_defs.svh"
module ldp_page_handler #(
	parameter int WIDTH = 16,
	parameter logic [31:0] SAVE_PERIOD = `LDP_SAVE_PERIOD,
	parameter logic [7:0] DIAG_CODE1 = 8'h80
) (
	input wire logic clock, // 20 MHz clock
	input wire logic rst_n, // Async reset, active low
	input wire logic cmdStart, // Command start pulse
	input wire ldp_pkg::ldp_cmd_type cmdKind, // Command kind
	input wire logic saveParametersBit, // Save request
	input wire logic pageControlField, // 0 threshold, 1 cumulative
	input wire logic [5:0] senseCode, // Page asked by sense
	input wire logic inValid, // Parameter byte valid
	input wire logic [7:0] inByte, // Parameter byte
	input wire logic inLast, // Last byte of list
	input wire logic outReady, // Consumer ready
	input wire logic countEvent, // Counted event
	output logic outValid, // Returned byte valid
	output logic [7:0] outByte, // Returned byte
	output logic outLast, // Last returned byte
	output ldp_pkg::ldp_status_type status, // Completion status
	output logic unitAttention, // Threshold attention level
	output logic saveStrobe, // Nonvolatile save pulse
	output logic [WIDTH-1:0] saveData // Value being saved
);
	typedef enum {S_IDLE, S_HDR, S_PHDR, S_PVAL, S_SEND, S_DONE} ldp_state_type;
	ldp_state_type stateReg, stateNext;
	logic [15:0] pageLenReg, pageLenNext, idxReg, idxNext;
	logic [7:0] plenReg, plenNext, pcodeReg, pcodeNext;
	logic [1:0] hdrReg, hdrNext;
	logic [7:0] valHiReg, valHiNext;
	logic errReg, errNext, diagArmReg, diagArmNext;
	ldp_pkg::ldp_ctrl_type ctrlReg, ctrlNext;
	logic [WIDTH-1:0] thrReg, thrNext;
	logic loadEn;
	logic [WIDTH-1:0] cumVal;
	logic atMax, hit;
	logic outValidReg, outValidNext, outLastReg, outLastNext;
	logic [7:0] outByteReg, outByteNext;
	ldp_pkg::ldp_status_type statusReg, statusNext;
	logic uaReg, uaNext, saveReg, saveNext;
	logic [WIDTH-1:0] saveDataReg, saveDataNext;
	logic [31:0] tickReg, tickNext;
	logic [7:0] pageByte;

	ldp_counter #(.WIDTH(WIDTH)) counter (
		.clock(clock),
		.rst_n(rst_n),
		.countEvent(countEvent),
		.freeze(atMax),
		.loadEn(loadEn),
		.loadValue({valHiReg, inByte}),
		.threshold(thrReg),
		.compareEnable(ctrlReg.compareEnable),
		.criterion(ctrlReg.thresholdMatchCriterion),
		.value(cumVal),
		.atMax(atMax),
		.thresholdHit(hit)
	);

	// ---------------------------------------------
	// Sense page image
	// ---------------------------------------------
	always_comb begin
		pageByte = 8'h00;
		if (diagArmReg) begin
			unique case (idxReg[2:0]) // [RL4] [RL5]
				3'h0: pageByte = `LDP_SUPP_DIAG_CODE; // [RL1]
				3'h3: pageByte = 8'h02;
				3'h4: pageByte = `LDP_SUPP_DIAG_CODE;
				3'h5: pageByte = DIAG_CODE1;
				default: pageByte = 8'h00;
			endcase
		end else begin
			unique case (idxReg[3:0]) // [RL6] [RL7] [RL9]
				4'h0: pageByte = {2'b00, senseCode};
				4'h3: pageByte = 8'h06;
				4'h5: pageByte = 8'h00;
				4'h6: pageByte = {atMax, ctrlReg.saveInhibit, ctrlReg.implicitSaveInhibit,
					ctrlReg.compareEnable, ctrlReg.thresholdMatchCriterion, 1'b0,
					ctrlReg.stringParameterFlag};
				4'h7: pageByte = 8'h02;
				4'h8: pageByte = pageControlField ? cumVal[15:8] : thrReg[15:8];
				4'h9: pageByte = pageControlField ? cumVal[7:0] : thrReg[7:0];
				default: pageByte = 8'h00;
			endcase
		end
	end

	// ---------------------------------------------
	// Command sequencer
	// ---------------------------------------------
	always_comb begin
		stateNext = stateReg;
		pageLenNext = pageLenReg;
		idxNext = idxReg;
		plenNext = plenReg;
		pcodeNext = pcodeReg;
		hdrNext = hdrReg;
		valHiNext = valHiReg;
		errNext = errReg;
		diagArmNext = diagArmReg;
		ctrlNext = ctrlReg;
		thrNext = thrReg;
		loadEn = 1'b0;
		outValidNext = 1'b0;
		outByteNext = outByteReg;
		outLastNext = 1'b0;
		statusNext = statusReg;
		statusNext.valid = 1'b0;
		saveNext = 1'b0;
		saveDataNext = saveDataReg;
		tickNext = tickReg + 32'd1;
		uaNext = uaReg || hit; // [RL17]
		unique case (stateReg)
			S_IDLE: begin
				if (cmdStart) begin
					idxNext = '0;
					errNext = 1'b0;
					hdrNext = '0;
					if (cmdKind == ldp_pkg::LDP_CMD_LOG_SENSE) begin
						uaNext = hit; // [RL17]
						stateNext = S_SEND; // [RL6]
					end else begin
						stateNext = S_HDR; // [RL6]
					end
				end
			end
			S_HDR: if (inValid) begin
				idxNext = idxReg + 16'd1;
				unique case (idxReg[1:0]) // [RL7] [RL5]
					2'h0: pcodeNext = (cmdKind == ldp_pkg::LDP_CMD_SEND_DIAG) ? inByte
						: (inByte & `LDP_PAGE_CODE_MASK);
					2'h2: pageLenNext = {inByte, 8'h00};
					2'h3: pageLenNext = {pageLenReg[15:8], inByte};
					default: ;
				endcase
				if (idxReg[1:0] == 2'h3) begin
					hdrNext = '0;
					if (cmdKind == ldp_pkg::LDP_CMD_SEND_DIAG) begin
						if ({pageLenReg[15:8], inByte} != 16'h0000 && pcodeReg == `LDP_SUPP_DIAG_CODE)
							errNext = 1'b1; // [RL2]
						else
							diagArmNext = 1'b1; // [RL3]
						stateNext = S_DONE;
					end else if ({pageLenReg[15:8], inByte} == 16'h0000) begin
						stateNext = inLast ? S_DONE : S_HDR;
						idxNext = '0;
					end else begin
						stateNext = S_PHDR;
					end
				end else if (inLast) begin
					stateNext = S_DONE;
				end
			end
			S_PHDR: if (inValid) begin
				pageLenNext = pageLenReg - 16'd1; // [RL20]
				hdrNext = hdrReg + 2'd1;
				if (hdrReg == 2'd2) begin
					ctrlNext.saveInhibit = inByte[`LDP_PCB_DS]; // [RL12]
					ctrlNext.implicitSaveInhibit = inByte[`LDP_PCB_TSD]; // [RL13]
					ctrlNext.stringParameterFlag = inByte[`LDP_PCB_LP];
					ctrlNext.compareEnable = inByte[`LDP_PCB_ETC] && !inByte[`LDP_PCB_LP]; // [RL19]
					ctrlNext.thresholdMatchCriterion = inByte[`LDP_PCB_LP] ? 2'h0
						: inByte[`LDP_PCB_TMC_HI:`LDP_PCB_TMC_LO]; // [RL14] [RL16]
					ctrlNext.updateInhibit = 1'b0; // [RL11]
				end
				if (hdrReg == 2'd3) begin
					plenNext = inByte; // [RL9]
					if ({8'h00, inByte} > pageLenReg - 16'd1 || pageLenReg == 16'd0)
						errNext = 1'b1; // [RL8]
					stateNext = S_PVAL;
				end
				if (inLast || pageLenReg <= 16'd1 && hdrReg != 2'd3) begin
					errNext = 1'b1; // [RL8]
					stateNext = S_DONE;
				end
			end
			S_PVAL: if (inValid) begin
				pageLenNext = pageLenReg - 16'd1; // [RL20]
				plenNext = plenReg - 8'd1;
				if (plenReg == 8'd2)
					valHiNext = inByte;
				if (plenReg == 8'd1 && !errReg) begin
					if (pageControlField)
						loadEn = 1'b1; // [RL10]
					else
						thrNext = {valHiReg, inByte};
				end
				if (plenReg == 8'd1) begin
					hdrNext = '0;
					if (pageLenReg == 16'd1)
						stateNext = inLast ? S_DONE : S_HDR; // [RL6]
					else
						stateNext = S_PHDR; // [RL20]
					idxNext = '0;
				end
				if (inLast && !(plenReg == 8'd1 && pageLenReg == 16'd1)) begin
					errNext = 1'b1; // [RL8]
					stateNext = S_DONE;
				end
			end
			S_SEND: begin
				if (!outValidReg || outReady) begin
					outValidNext = 1'b1;
					outByteNext = pageByte;
					idxNext = idxReg + 16'd1;
					if (idxReg == (diagArmReg ? 16'd5 : 16'd9)) begin
						outLastNext = 1'b1;
						diagArmNext = 1'b0;
						stateNext = S_DONE;
					end
				end else begin
					outValidNext = 1'b1;
				end
			end
			S_DONE: begin
				if (!outValidReg || outReady) begin
					statusNext.valid = 1'b1;
					statusNext.senseKey = errReg ? `LDP_SK_ILLEGAL_REQUEST
						: (uaReg ? `LDP_SK_UNIT_ATTENTION : 4'h0); // [RL2] [RL8] [RL17]
					statusNext.addSense = errReg ? `LDP_ASC_INVALID_PARAM_LIST
						: (uaReg ? `LDP_ASC_THRESHOLD_MET : 8'h00);
					if (saveParametersBit && !ctrlReg.saveInhibit) begin
						saveNext = 1'b1; // [RL12]
						saveDataNext = pageControlField ? cumVal : thrReg;
					end
					stateNext = S_IDLE;
				end else begin
					outValidNext = 1'b1;
					outLastNext = outLastReg;
				end
			end
			default: stateNext = S_IDLE;
		endcase
		if (!ctrlReg.implicitSaveInhibit && tickReg >= SAVE_PERIOD - 32'd1) begin
			tickNext = '0;
			saveNext = 1'b1; // [RL13]
			saveDataNext = cumVal;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stateReg <= S_IDLE;
			pageLenReg <= '0;
			idxReg <= '0;
			plenReg <= '0;
			pcodeReg <= '0;
			hdrReg <= '0;
			valHiReg <= '0;
			errReg <= 1'b0;
			diagArmReg <= 1'b0;
			ctrlReg <= '0;
			thrReg <= '0;
			outValidReg <= 1'b0;
			outByteReg <= '0;
			outLastReg <= 1'b0;
			statusReg <= '0;
			uaReg <= 1'b0;
			saveReg <= 1'b0;
			saveDataReg <= '0;
			tickReg <= '0;
		end else begin
			stateReg <= stateNext;
			pageLenReg <= pageLenNext;
			idxReg <= idxNext;
			plenReg <= plenNext;
			pcodeReg <= pcodeNext;
			hdrReg <= hdrNext;
			valHiReg <= valHiNext;
			errReg <= errNext;
			diagArmReg <= diagArmNext;
			ctrlReg <= ctrlNext;
			thrReg <= thrNext;
			outValidReg <= outValidNext;
			outByteReg <= outByteNext;
			outLastReg <= outLastNext;
			statusReg <= statusNext;
			uaReg <= uaNext;
			saveReg <= saveNext;
			saveDataReg <= saveDataNext;
			tickReg <= tickNext;
		end
	end

	assign outValid = outValidReg;
	assign outByte = outByteReg;
	assign outLast = outLastReg;
	assign status = statusReg;
	assign unitAttention = uaReg;
	assign saveStrobe = saveReg;
	assign saveData = saveDataReg;

	AST_UA_ON_HIT: assert property (@(posedge clock) disable iff (!rst_n)
		hit |=> unitAttention) else $error("Hit without attention"); // [RL17]
	AST_ERR_STATUS: assert property (@(posedge clock) disable iff (!rst_n)
		status.valid && errReg |-> status.senseKey == `LDP_SK_ILLEGAL_REQUEST)
		else $error("Bad error status"); // [RL8]
	AST_STRING_NO_CMP: assert property (@(posedge clock) disable iff (!rst_n)
		ctrlReg.stringParameterFlag |-> !ctrlReg.compareEnable) else $error("String compares"); // [RL19]
	AST_NO_SAVE_DS: assert property (@(posedge clock) disable iff (!rst_n)
		stateReg == S_DONE && ctrlReg.saveInhibit && ctrlReg.implicitSaveInhibit |=> !saveStrobe)
		else $error("Save while inhibited"); // [RL12]
	AST_FIRST_CODE: assert property (@(posedge clock) disable iff (!rst_n)
		stateReg == S_SEND && diagArmReg && idxReg == 16'd4 && (!outValidReg || outReady)
		|=> outByte == `LDP_SUPP_DIAG_CODE)
		else $error("List not led by 00h"); // [RL4]
endmodule

// >>> ldp_initiator_model.sv
// Initiator-side model: consumes returned pages, records status and saves
`timescale 1ns/1ps
module ldp_initiator_model (
	input wire logic clock, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic slow, // Stall every other cycle
	input wire logic outValid, // Returned byte valid
	input wire logic [7:0] outByte, // Returned byte
	input wire logic outLast, // Last returned byte
	input wire ldp_pkg::ldp_status_type status, // Completion status
	input wire logic saveStrobe, // Save pulse
	input wire logic [15:0] saveData, // Saved value
	output logic outReady // Consumer ready
);
	logic [7:0] got[$];
	ldp_pkg::ldp_status_type stVal;
	int stCount;
	int lastCount;
	int saveCount;
	logic [15:0] lastSave;
	// ----------------------------------------
	// Byte consumer and status recorder
	// ----------------------------------------
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			outReady <= 1'b0;
			stCount <= 0;
			lastCount <= 0;
			saveCount <= 0;
			lastSave <= 16'h0000;
		end else begin
			outReady <= slow ? ~outReady : 1'b1;
			if (outValid && outReady) begin
				got.push_back(outByte);
				if (outLast) begin
					lastCount <= lastCount + 1;
				end
			end
			if (status.valid) begin
				stVal <= status;
				stCount <= stCount + 1;
			end
			if (saveStrobe) begin
				saveCount <= saveCount + 1;
				lastSave <= saveData;
			end
		end
	end
endmodule

// >>> ldp_page_handler_tb.sv
// Self-checking testbench for the log and diagnostic page handler
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
	$display("[FAIL] %0t: got %0h exp %0h", $time, (a), (b)); end end
module ldp_page_handler_tb;
	typedef logic [7:0] ldp_bytes_type[$];
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic cmdStart = 1'b0;
	ldp_pkg::ldp_cmd_type cmdKind = ldp_pkg::LDP_CMD_SEND_DIAG;
	logic saveParametersBit = 1'b0;
	logic pageControlField = 1'b0;
	logic [5:0] senseCode = 6'h02;
	logic inValid = 1'b0;
	logic [7:0] inByte = 8'h00;
	logic inLast = 1'b0;
	logic countEvent = 1'b0;
	logic slow = 1'b0;
	logic outReady;
	logic outValid;
	logic [7:0] outByte;
	logic outLast;
	ldp_pkg::ldp_status_type status;
	logic unitAttention;
	logic saveStrobe;
	logic [15:0] saveData;
	int errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	ldp_page_handler #(.WIDTH(16), .SAVE_PERIOD(32'd16)) DUT (.clock(clock), .rst_n(rst_n),
		.cmdStart(cmdStart), .cmdKind(cmdKind), .saveParametersBit(saveParametersBit),
		.pageControlField(pageControlField), .senseCode(senseCode), .inValid(inValid),
		.inByte(inByte), .inLast(inLast), .outReady(outReady), .countEvent(countEvent),
		.outValid(outValid), .outByte(outByte), .outLast(outLast), .status(status),
		.unitAttention(unitAttention), .saveStrobe(saveStrobe), .saveData(saveData));
	ldp_initiator_model partner (.clock(clock), .rst_n(rst_n), .slow(slow),
		.outValid(outValid), .outByte(outByte), .outLast(outLast), .status(status),
		.saveStrobe(saveStrobe), .saveData(saveData), .outReady(outReady));
	initial begin
		forever #25 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic run_cmd(input ldp_pkg::ldp_cmd_type kind, input logic pc, input logic sp,
		input ldp_bytes_type b);
		int n0;
		int i;
		n0 = partner.stCount;
		partner.got.delete();
		@(posedge clock);
		cmdStart <= 1'b1;
		cmdKind <= kind;
		pageControlField <= pc;
		saveParametersBit <= sp;
		@(posedge clock);
		cmdStart <= 1'b0;
		for (i = 0; i < b.size(); i++) begin
			inValid <= 1'b1;
			inByte <= b[i];
			inLast <= (i == b.size() - 1);
			@(posedge clock);
		end
		inValid <= 1'b0;
		inLast <= 1'b0;
		i = 0;
		while (partner.stCount == n0 && i < 300) begin
			@(posedge clock);
			i++;
		end
		@(posedge clock);
		`CHK(partner.stCount != n0, 1'b1)
	endtask
	task automatic sel(input logic pc, input logic [7:0] ctl, input logic [15:0] v,
		input logic sp);
		run_cmd(ldp_pkg::LDP_CMD_LOG_SELECT, pc, sp,
			'{8'h02, 8'h00, 8'h00, 8'h06, 8'h00, 8'h00, ctl, 8'h02, v[15:8], v[7:0]});
	endtask
	task automatic sense();
		ldp_bytes_type none;
		run_cmd(ldp_pkg::LDP_CMD_LOG_SENSE, 1'b1, 1'b0, none);
	endtask
	task automatic chk_st(input logic [3:0] key, input logic [7:0] asc);
		`CHK(partner.stVal.senseKey, key)
		`CHK(partner.stVal.addSense, asc)
	endtask
	task automatic chk_log(input logic [15:0] v);
		`CHK(partner.got.size(), 10)
		if (partner.got.size() == 10) begin
			`CHK(partner.got[0], {2'b00, senseCode})
			`CHK({partner.got[1], partner.got[2], partner.got[3]}, 24'h000006)
			`CHK({partner.got[7], partner.got[8], partner.got[9]}, {8'h02, v})
		end
	endtask
	task automatic ev(input int n);
		repeat (n) begin
			@(posedge clock);
			countEvent <= 1'b1;
			@(posedge clock);
			countEvent <= 1'b0;
		end
		repeat (4) @(posedge clock);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_diag();
		ldp_bytes_type e;
		int nl;
		run_cmd(ldp_pkg::LDP_CMD_SEND_DIAG, 1'b0, 1'b0, '{8'h00, 8'h00, 8'h00, 8'h00});
		chk_st(4'h0, 8'h00);
		nl = partner.lastCount;
		slow <= 1'b1;
		sense();
		slow <= 1'b0;
		e = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h80};
		`CHK(partner.got.size(), 6)
		for (int i = 0; i < 6 && i < partner.got.size(); i++) begin
			`CHK(partner.got[i], e[i])
		end
		`CHK(partner.lastCount, nl + 1)
		run_cmd(ldp_pkg::LDP_CMD_SEND_DIAG, 1'b0, 1'b0, '{8'h00, 8'h00, 8'h00, 8'h01});
		chk_st(4'h5, 8'h26);
		$display("test diag done");
	endtask
	task automatic t_select();
		sel(1'b1, 8'h80, 16'h0005, 1'b0);
		chk_st(4'h0, 8'h00);
		ev(2);
		sense();
		chk_log(16'h0007);
		run_cmd(ldp_pkg::LDP_CMD_LOG_SELECT, 1'b1, 1'b0,
			'{8'h02, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00});
		chk_st(4'h5, 8'h26);
		$display("test select done");
	endtask
	task automatic t_thresh();
		logic [4:0] e1;
		logic [4:0] e2;
		logic [7:0] ctl;
		e1 = 5'b00011;
		e2 = 5'b01101;
		for (int k = 0; k < 5; k++) begin
			ctl = (k < 4) ? (8'h10 | 8'(k << 2)) : 8'h04;
			sel(1'b0, ctl, 16'h0002, 1'b0);
			sel(1'b1, ctl, 16'h0001, 1'b0);
			sense();
			ev(1);
			`CHK(unitAttention, e1[k])
			sense();
			`CHK(unitAttention, 1'b0)
			ev(1);
			`CHK(unitAttention, e2[k])
			sense();
		end
		$display("test threshold done");
	endtask
	task automatic t_save();
		int n;
		sel(1'b1, 8'h20, 16'h1234, 1'b1);
		repeat (4) @(posedge clock);
		`CHK(partner.lastSave, 16'h1234)
		n = partner.saveCount;
		sel(1'b1, 8'h60, 16'h4321, 1'b1);
		repeat (40) @(posedge clock);
		`CHK(partner.saveCount, n)
		sel(1'b1, 8'h40, 16'h0abc, 1'b0);
		repeat (40) @(posedge clock);
		`CHK(partner.saveCount > n, 1'b1)
		`CHK(partner.lastSave, 16'h0abc)
		$display("test save done");
	endtask
	task automatic t_sat();
		sel(1'b1, 8'h20, 16'hfffe, 1'b0);
		ev(3);
		sense();
		chk_log(16'hffff);
		if (partner.got.size() == 10) begin
			`CHK(partner.got[6][7], 1'b1)
		end
		ev(1);
		sense();
		chk_log(16'hffff);
		$display("test saturate done");
	endtask
	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		t_diag();
		t_select();
		t_thresh();
		t_save();
		t_sat();
		wrap_up();
	end
endmodule
